// [shared/psr_pkg.sv]
/*
  Constants, register map, field layout and state types for the parallel
  speed reference decoder. Assumes one 25 MHz clock domain and a plain
  register port with read data one cycle after the read strobe.
*/
// Functional notes
// - All-ones binary word gives full 100% speed
// - Five-digit BCD: sign is data, positive only
// - Five-digit BCD lowest digit even, 0.02 Hz step
// - 8-bit board: lines 1-8 weights, 9 sign
// - 8-bit board ignores five-digit BCD format
// - Range and scaling from both selectors together
// - Monitor unit 0.01 Hz or 0.01% by selector
// - Percent BCD codes 0-2; 3 or 4 digits, 2 on the 8-bit board
// - Coarse percent BCD limited to 110.0%
// - Hz BCD codes 3-5, never beyond 400 Hz
// - Five-digit BCD 0.01 Hz up to 399.98 Hz
// - 12-bit binary: 4095 is 100%
// - 16-bit binary: 30000 is 100%, 33000 max
// - Pole count selector: BCD in 1 rpm units
// - User units: lower digits 100%, fifth decimal
// - User 1000 setting, fifth digit 1-3: 10000 per 100%, 1000 max
// - 8-bit two-digit BCD Hz codes, 159 Hz max
// - 8-bit binary: 255 is 100%
// - Word width from board type and switch together
`default_nettype none
package psr_pkg;

  localparam int REG_AW = 3;
  localparam int REG_DW = 32;
  localparam int MAG_W = 24;
  localparam int Q16_SHIFT = 16;

  // Register indices on the register port
  localparam logic [REG_AW-1:0] ADDR_CTRL = 3'h0;
  localparam logic [REG_AW-1:0] ADDR_DISP = 3'h1;
  localparam logic [REG_AW-1:0] ADDR_CONV_IN = 3'h2;
  localparam logic [REG_AW-1:0] ADDR_CONV_MON = 3'h3;
  localparam logic [REG_AW-1:0] ADDR_STATUS = 3'h4;
  localparam logic [REG_AW-1:0] ADDR_REF = 3'h5;
  localparam logic [REG_AW-1:0] ADDR_MON = 3'h6;
  localparam logic [REG_AW-1:0] ADDR_RAW = 3'h7;

  // Field positions
  localparam int CTRL_BOARD8_BIT = 0;
  localparam int CTRL_FMT_LSB = 1;
  localparam int FMT_W = 3;
  localparam int DISP_W = 16;

  // Reset values
  localparam logic [FMT_W-1:0] FMT_RESET = 3'h0;
  localparam logic [DISP_W-1:0] DISP_RESET = 16'h0000;
  localparam logic [MAG_W-1:0] CONV_RESET = 24'h010000; // 1.0 in Q16

  // Input format selector codes
  localparam logic [FMT_W-1:0] FMT_PCT1 = 3'h0;
  localparam logic [FMT_W-1:0] FMT_PCT01 = 3'h1;
  localparam logic [FMT_W-1:0] FMT_PCT001 = 3'h2;
  localparam logic [FMT_W-1:0] FMT_HZ1 = 3'h3;
  localparam logic [FMT_W-1:0] FMT_HZ01 = 3'h4;
  localparam logic [FMT_W-1:0] FMT_HZ001 = 3'h5;
  localparam logic [FMT_W-1:0] FMT_U5 = 3'h6;
  localparam logic [FMT_W-1:0] FMT_BIN = 3'h7;

  // Display unit selector boundaries
  localparam logic [DISP_W-1:0] DISP_HZ = 16'h0000;
  localparam logic [DISP_W-1:0] DISP_RPM_MIN = 16'h0002;
  localparam logic [DISP_W-1:0] DISP_RPM_MAX = 16'h0027; // 39 poles
  localparam logic [DISP_W-1:0] DISP_DEC_STEP = 16'h2710; // 10000
  localparam logic [DISP_W-1:0] DISP_USER_ONE = 16'h03E8; // 1000

  // Limits on the raw decoded magnitude
  localparam logic [MAG_W-1:0] LIM_PCT1 = 24'h00006E; // 110%
  localparam logic [MAG_W-1:0] LIM_PCT01 = 24'h00044C; // 110.0%
  localparam logic [MAG_W-1:0] LIM_PCT001 = 24'h002AF8; // 110.00%
  localparam logic [MAG_W-1:0] LIM_HZ1 = 24'h000190; // 400 Hz
  localparam logic [MAG_W-1:0] LIM_HZ01 = 24'h000FA0; // 400.0 Hz
  localparam logic [MAG_W-1:0] LIM_HZ001 = 24'h009C40; // 400.00 Hz
  localparam logic [MAG_W-1:0] LIM_U5 = 24'h009C3E; // 399.98 Hz
  localparam logic [MAG_W-1:0] LIM_BIN16 = 24'h0080E8; // 33000
  localparam logic [MAG_W-1:0] LIM_USER1000 = 24'h0003E8; // 1000
  localparam logic [MAG_W-1:0] LIM_NONE = 24'hFFFFFF;

  // Scaling into 0.01% units; Q16 factors rounded up so full scale lands on 100.00%
  localparam logic [MAG_W-1:0] PCT_FULL = 24'h002710; // 100.00%
  localparam logic [MAG_W-1:0] MUL100 = 24'h000064;
  localparam logic [MAG_W-1:0] MUL10 = 24'h00000A;
  localparam logic [MAG_W-1:0] K_BIN12 = 24'h027128; // 10000/4095
  localparam logic [MAG_W-1:0] K_BIN16 = 24'h005556; // 10000/30000
  localparam logic [MAG_W-1:0] K_BIN8 = 24'h273738; // 10000/255
  localparam logic [47:0] Q16_HALF = 48'h000000008000;

  // Binary word masks
  localparam logic [15:0] MASK8 = 16'h00FF;
  localparam logic [15:0] MASK12 = 16'h0FFF;
  localparam logic [15:0] MASK16 = 16'hFFFF;

  // Digit checks
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [2:0] NDIG8 = 3'h2;
  localparam logic [2:0] NDIG12 = 3'h3;
  localparam logic [2:0] NDIG16 = 3'h4;

  typedef enum logic [2:0] {
    MODE_BCD, MODE_BIN, MODE_U5, MODE_RPM, MODE_USER, MODE_OFF
  } psr_mode_e;

  typedef struct packed {
    logic board8;
    logic [FMT_W-1:0] fmt;
    logic [DISP_W-1:0] disp;
    logic [MAG_W-1:0] conv_in;
    logic [MAG_W-1:0] conv_mon;
    logic [MAG_W-1:0] ref_val;
    logic [MAG_W-1:0] mon_val;
    logic [16:0] raw_word;
    logic [1:0] mon_dp;
    logic reverse;
    logic last_bad;
    logic upd;
    logic rej;
    logic [REG_DW-1:0] rdata;
  } psr_state_s;

endpackage
`default_nettype wire

// [design/psr_decoder.sv]
/*
  Parallel speed reference decoder: turns signed BCD, signed binary or
  unsigned five-digit BCD words on the option-board terminals into an
  internal reference in 0.01% of maximum frequency and a monitor value.
  Assumes terminal inputs already synchronous to MCLK_IN and a register
  master that never issues read and write strobes together.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_decoder
  import psr_pkg::*;
(
  input wire logic MCLK_IN, // 25 MHz clock
  input wire logic NRST_IN, // Async reset, active low
  input wire logic [REG_AW-1:0] ADDR_IN, // Register index
  input wire logic [REG_DW-1:0] WDATA_IN, // Write data
  input wire logic WR_IN, // Write strobe
  input wire logic RD_IN, // Read strobe
  output logic [REG_DW-1:0] RDATA_OUT, // Read data, cycle after strobe
  input wire logic [15:0] DATA_IN, // Reference data lines
  input wire logic SIGN_IN, // Sign line, 1 is reverse; data bit in the five-digit format
  input wire logic STROBE_IN, // Read strobe from controller
  input wire logic WIDTH_SW_IN, // Word width switch, 1 is 16 bits, ignored on the 8-bit board
  output logic [MAG_W-1:0] REF_OUT, // Internal reference, 0.01%
  output logic [MAG_W-1:0] MON_OUT, // Reference monitor value
  output logic [1:0] MON_DECIMAL_OUT, // Monitor decimal places
  output logic REVERSE_OUT, // Accepted reference is reverse
  output logic REF_UPDATE_OUT, // Pulse on accepted word
  output logic REF_REJECT_OUT // Pulse on refused word
);

  psr_state_s state_reg;
  psr_state_s state_next;
  logic rst_meta_reg;
  logic rst_n_reg;

  // BCD value of the lowest ndig nibbles, top nibble allowed up to 15
  function automatic logic [MAG_W-1:0] bcd_value(input logic [15:0] w,
                                                input logic [2:0] ndig);
    logic [MAG_W-1:0] acc;
    acc = '0;
    for (int k = 3; k >= 0; k--) begin
      if (k < int'(ndig)) begin
        acc = MAG_W'(acc * MUL10 + MAG_W'(w[4*k +: 4]));
      end
    end
    return acc;
  endfunction

  // Lower digits must be decimal; only the top digit may reach 15
  function automatic logic digits_ok(input logic [15:0] w, input logic [2:0] ndig);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (k < int'(ndig) - 1 && w[4*k +: 4] > BCD_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Q16 fixed point product, rounded to nearest
  function automatic logic [MAG_W-1:0] scale_q16(input logic [MAG_W-1:0] mag,
                                                input logic [MAG_W-1:0] k);
    logic [47:0] p;
    p = 48'(mag) * 48'(k) + Q16_HALF;
    return p[Q16_SHIFT +: MAG_W];
  endfunction

  // Selector pair to decode mode; rpm and user display ignore the format code
  function automatic psr_mode_e mode_of(input logic [DISP_W-1:0] disp,
                                        input logic board8,
                                        input logic [FMT_W-1:0] fmt);
    psr_mode_e m;
    m = MODE_BCD;
    if (disp >= DISP_RPM_MIN && disp <= DISP_RPM_MAX) begin
      m = MODE_RPM;
    end else if (disp > DISP_RPM_MAX) begin
      m = MODE_USER;
    end else if (board8 && fmt == FMT_U5) begin
      m = MODE_OFF;
    end else if (fmt == FMT_BIN) begin
      m = MODE_BIN;
    end else if (fmt == FMT_U5) begin
      m = MODE_U5;
    end
    return m;
  endfunction

  // Fifth digit of the user setting, 0 to 3 decimal places
  function automatic logic [1:0] user_decimals(input logic [DISP_W-1:0] disp);
    logic [1:0] d;
    d = 2'h0;
    if (disp >= 16'(3 * DISP_DEC_STEP)) begin
      d = 2'h3;
    end else if (disp >= 16'(2 * DISP_DEC_STEP)) begin
      d = 2'h2;
    end else if (disp >= DISP_DEC_STEP) begin
      d = 2'h1;
    end
    return d;
  endfunction

  // Five-digit word: lowest digit even and at most 8, digits two to four decimal
  function automatic logic u5_ok(input logic [15:0] w);
    logic ok;
    ok = w[2:0] <= BCD_DIGIT_MAX[3:1];
    for (int k = 0; k < 3; k++) begin
      if (w[3+4*k +: 4] > BCD_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Status word: mode, last refusal, direction, width and inactive format
  function automatic logic [REG_DW-1:0] status_word(input psr_mode_e m, input logic bad,
                                                    input logic rev, input logic wide);
    return REG_DW'({3'(m), bad, rev, wide, m == MODE_OFF});
  endfunction

  // Reset release through two flops so all state leaves reset together
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Decode, limit check, scaling and register access
  always_comb begin
    psr_mode_e mode;
    logic [2:0] ndig;
    logic [15:0] bin_word;
    logic [15:0] bin_mask;
    logic [MAG_W-1:0] raw;
    logic [MAG_W-1:0] lim;
    logic [MAG_W-1:0] pct;
    logic [MAG_W-1:0] hz;
    logic [MAG_W-1:0] mon;
    logic [1:0] dec5;
    logic [DISP_W-1:0] disp_low;
    logic is_hz;
    logic ok;
    logic neg;
    logic accept;
    mode = MODE_BCD;
    ndig = NDIG12;
    bin_word = '0;
    bin_mask = MASK12;
    raw = '0;
    lim = LIM_NONE;
    pct = '0;
    hz = '0;
    mon = '0;
    dec5 = '0;
    disp_low = '0;
    is_hz = 1'b0;
    ok = 1'b0;
    neg = 1'b0;
    accept = 1'b0;
    state_next = state_reg;
    state_next.upd = 1'b0;
    state_next.rej = 1'b0;
    state_next.rdata = '0;

    // Both selectors pick the decode mode together; a format change alone
    // never reaches the rpm or user scaling
    mode = mode_of(state_reg.disp, state_reg.board8, state_reg.fmt);

    // Width from board type and switch
    if (state_reg.board8) begin
      ndig = NDIG8;
      bin_mask = MASK8;
    end else if (WIDTH_SW_IN) begin
      ndig = NDIG16;
      bin_mask = MASK16;
    end
    // Lines beyond the active width are masked, except in the five-digit format
    bin_word = DATA_IN & bin_mask;

    // Fifth digit of the user setting gives the decimal position
    dec5 = user_decimals(state_reg.disp);
    disp_low = 16'(state_reg.disp - 16'(dec5) * DISP_DEC_STEP);

    unique case (mode)
      MODE_BCD: begin
        ok = digits_ok(DATA_IN, ndig);
        raw = bcd_value(DATA_IN, ndig);
        // Percent codes land in 0.01% directly; Hz codes go through the factor
        case (state_reg.fmt)
          FMT_PCT1: begin
            lim = LIM_PCT1;
            pct = MAG_W'(raw * MUL100);
          end
          FMT_PCT01: begin
            lim = LIM_PCT01;
            pct = MAG_W'(raw * MUL10);
          end
          FMT_PCT001: begin
            lim = LIM_PCT001;
            pct = raw;
          end
          FMT_HZ1: begin
            lim = LIM_HZ1;
            hz = MAG_W'(raw * MUL100);
            is_hz = 1'b1;
          end
          FMT_HZ01: begin
            lim = LIM_HZ01;
            hz = MAG_W'(raw * MUL10);
            is_hz = 1'b1;
          end
          FMT_HZ001: begin
            lim = LIM_HZ001;
            hz = raw;
            is_hz = 1'b1;
          end
          default: begin
            ok = 1'b0;
          end
        endcase
      end
      MODE_BIN: begin
        // All-ones is caught before scaling, so full scale is exact, not rounded
        ok = 1'b1;
        raw = MAG_W'(bin_word);
        if (bin_word == bin_mask) begin
          pct = PCT_FULL;
        end else if (state_reg.board8) begin
          pct = scale_q16(raw, K_BIN8);
        end else if (WIDTH_SW_IN) begin
          lim = LIM_BIN16;
          pct = scale_q16(raw, K_BIN16);
        end else begin
          pct = scale_q16(raw, K_BIN12);
        end
      end
      MODE_U5: begin
        // Lowest digit carries only 2, 4, 8 weights; sign line and DATA_IN[15] form digit five
        ok = u5_ok(DATA_IN);
        raw = MAG_W'(bcd_value({2'h0, SIGN_IN, DATA_IN[15]}, 3'h1) * 24'(DISP_DEC_STEP)
              + bcd_value({DATA_IN[14:3], DATA_IN[2:0], 1'b0}, NDIG16));
        lim = LIM_U5;
        hz = raw;
        is_hz = 1'b1;
      end
      MODE_RPM: begin
        // Rpm to percent needs poles and top speed, so software sets the factor
        ok = digits_ok(DATA_IN, ndig);
        raw = bcd_value(DATA_IN, ndig);
        pct = scale_q16(raw, state_reg.conv_in);
      end
      MODE_USER: begin
        // The x1000 setting with a nonzero fifth digit has an exact scale; other settings use the factor
        ok = digits_ok(DATA_IN, ndig);
        raw = bcd_value(DATA_IN, ndig);
        if (disp_low == DISP_USER_ONE && dec5 != 2'h0) begin
          lim = LIM_USER1000;
          pct = raw;
        end else begin
          pct = scale_q16(raw, state_reg.conv_in);
        end
      end
      MODE_OFF: begin
        // Eight lines cannot carry five digits, so every word is refused
        ok = 1'b0;
      end
    endcase

    // Frequency references convert to percent through the software factor
    if (is_hz) begin
      pct = scale_q16(hz, state_reg.conv_in);
    end

    // Monitor unit follows the display selector
    if (mode == MODE_RPM || mode == MODE_USER) begin
      mon = raw;
    end else if (state_reg.disp == DISP_HZ) begin
      mon = is_hz ? hz : scale_q16(pct, state_reg.conv_mon);
    end else begin
      mon = pct;
    end

    // Sign line is a data bit in the five-digit format, never a direction
    neg = SIGN_IN && mode != MODE_U5;
    accept = ok && raw <= lim;

    // Word taken only while the controller holds its strobe
    if (STROBE_IN) begin
      // A held strobe decodes again every cycle; the newest word wins
      state_next.last_bad = !accept;
      if (accept) begin
        state_next.ref_val = neg ? MAG_W'(-pct) : pct;
        state_next.mon_val = neg ? MAG_W'(-mon) : mon;
        state_next.mon_dp = (mode == MODE_USER) ? dec5 : 2'h0;
        state_next.reverse = neg;
        state_next.raw_word = {SIGN_IN, DATA_IN};
        state_next.upd = 1'b1;
      end else begin
        state_next.rej = 1'b1;
      end
    end

    // Register writes; status and result indices are read only, writes dropped
    if (WR_IN) begin
      case (ADDR_IN)
        ADDR_CTRL: begin
          state_next.board8 = WDATA_IN[CTRL_BOARD8_BIT];
          state_next.fmt = WDATA_IN[CTRL_FMT_LSB +: FMT_W];
        end
        ADDR_DISP: state_next.disp = WDATA_IN[DISP_W-1:0];
        ADDR_CONV_IN: state_next.conv_in = WDATA_IN[MAG_W-1:0];
        ADDR_CONV_MON: state_next.conv_mon = WDATA_IN[MAG_W-1:0];
        default: begin
        end
      endcase
    end

    // Register reads; unmapped bits read as zero
    if (RD_IN) begin
      case (ADDR_IN)
        ADDR_CTRL: state_next.rdata = REG_DW'({state_reg.fmt, state_reg.board8});
        ADDR_DISP: state_next.rdata = REG_DW'(state_reg.disp);
        ADDR_CONV_IN: state_next.rdata = REG_DW'(state_reg.conv_in);
        ADDR_CONV_MON: state_next.rdata = REG_DW'(state_reg.conv_mon);
        ADDR_STATUS: state_next.rdata = status_word(mode, state_reg.last_bad,
                                                    state_reg.reverse, ndig == NDIG16);
        ADDR_REF: state_next.rdata = REG_DW'(state_reg.ref_val);
        ADDR_MON: state_next.rdata = REG_DW'(state_reg.mon_val);
        ADDR_RAW: state_next.rdata = REG_DW'(state_reg.raw_word);
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK_IN or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= '{board8: 1'b0, fmt: FMT_RESET, disp: DISP_RESET,
                     conv_in: CONV_RESET, conv_mon: CONV_RESET, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign RDATA_OUT = state_reg.rdata;
  assign REF_OUT = state_reg.ref_val;
  assign MON_OUT = state_reg.mon_val;
  assign MON_DECIMAL_OUT = state_reg.mon_dp;
  assign REVERSE_OUT = state_reg.reverse;
  assign REF_UPDATE_OUT = state_reg.upd;
  assign REF_REJECT_OUT = state_reg.rej;

endmodule
`default_nettype wire

// [dv/psr_ctrl_model.sv]
/*
  Model of the external controller that drives the reference lines.
  Assumes the bench calls send() from one process, clocked by MCLK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_ctrl_model (
  input wire logic clk_in, // Decoder clock
  output logic [15:0] data_out, // Reference data lines
  output logic sign_out, // Sign line
  output logic strobe_out // Read strobe
);
  // Lines idle with a pattern, never a stale word
  initial begin
    data_out = 16'hA5A5;
    sign_out = 1'b0;
    strobe_out = 1'b0;
  end

  // Word settles for setup cycles before the strobe; slow partners use more
  task automatic send(input logic [15:0] d, input logic s, input int setup);
    @(posedge clk_in);
    data_out <= d;
    sign_out <= s;
    repeat (setup) @(posedge clk_in);
    strobe_out <= 1'b1;
    @(posedge clk_in);
    strobe_out <= 1'b0;
    data_out <= ~d; // Released: inverse so a late sample shows
    sign_out <= ~s;
  endtask
endmodule
`default_nettype wire

// [dv/psr_decoder_monitor.sv]
/*
  Port checker for the reference decoder, bound to its top module.
  Assumes the register master never raises both strobes at once.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_decoder_monitor
  import psr_pkg::*;
(
  input wire logic MCLK_IN, // Clock
  input wire logic NRST_IN, // Reset, active low
  input wire logic [REG_AW-1:0] ADDR_IN, // Register index
  input wire logic RD_IN, // Read strobe
  input wire logic [REG_DW-1:0] RDATA_OUT, // Read data
  input wire logic STROBE_IN, // Controller strobe
  input wire logic [MAG_W-1:0] REF_OUT, // Reference
  input wire logic REVERSE_OUT, // Reverse flag
  input wire logic REF_UPDATE_OUT, // Accept pulse
  input wire logic REF_REJECT_OUT // Refuse pulse
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);

  // Answers only ever follow a strobe cycle
  a_upd_after_strobe: assert property (REF_UPDATE_OUT |-> $past(STROBE_IN))
    else $error("update without strobe");
  a_rej_after_strobe: assert property (REF_REJECT_OUT |-> $past(STROBE_IN))
    else $error("reject without strobe");
  a_strobe_answered: assert property (STROBE_IN |=> REF_UPDATE_OUT != REF_REJECT_OUT)
    else $error("strobe cycle not answered once");
  a_quiet_idle: assert property (!STROBE_IN |=> !REF_UPDATE_OUT && !REF_REJECT_OUT)
    else $error("answer without strobe");
  // Refused words leave the reference alone
  a_ref_holds: assert property (!REF_UPDATE_OUT |-> $stable(REF_OUT) && $stable(REVERSE_OUT))
    else $error("reference moved without update");
  a_sign_match: assert property (REF_UPDATE_OUT && REF_OUT != '0 |->
    REF_OUT[MAG_W-1] == REVERSE_OUT)
    else $error("reference sign and reverse flag differ");
  // Read data only in the cycle after a read
  a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == '0)
    else $error("read data outside read cycle");
  a_read_ref: assert property (RD_IN && ADDR_IN == ADDR_REF |=>
    RDATA_OUT[MAG_W-1:0] == $past(REF_OUT))
    else $error("reference read mismatch");

  c_reject: cover property (REF_REJECT_OUT);
  c_reverse: cover property (REF_UPDATE_OUT && REVERSE_OUT);
  c_read_ref: cover property (RD_IN && ADDR_IN == ADDR_REF);
endmodule

bind psr_decoder psr_decoder_monitor psr_decoder_monitor_inst (.MCLK_IN, .NRST_IN, .ADDR_IN,
  .RD_IN, .RDATA_OUT, .STROBE_IN, .REF_OUT, .REVERSE_OUT, .REF_UPDATE_OUT, .REF_REJECT_OUT);
`default_nettype wire

// [dv/psr_decoder_test.sv]
/*
  Self-checking bench for the reference decoder: drivers queue expected
  results, a watcher compares them. Assumes the controller model.
*/
`timescale 1ns/1ps
`default_nettype none
module psr_decoder_test;
  import psr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, width_sw = 1'b1;
  logic [REG_AW-1:0] addr = '0;
  logic [REG_DW-1:0] wdata = '0, rdata;
  logic [15:0] data;
  logic sign, strobe, rev, upd, rej;
  logic [MAG_W-1:0] ref_v, mon;
  logic [1:0] mdp;
  logic [16:0] w5;
  logic [25:0] q[$];
  logic [31:0] rq[$];
  int error_cnt = 0, n_checks = 0, seed = 32'h238BA702, m;

  always #20 clk = ~clk;

  psr_decoder psr_decoder_inst (.MCLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .DATA_IN(data),
    .SIGN_IN(sign), .STROBE_IN(strobe), .WIDTH_SW_IN(width_sw), .REF_OUT(ref_v),
    .MON_OUT(mon), .MON_DECIMAL_OUT(mdp), .REVERSE_OUT(rev), .REF_UPDATE_OUT(upd),
    .REF_REJECT_OUT(rej));
  psr_ctrl_model psr_ctrl_model_inst (.clk_in(clk), .data_out(data), .sign_out(sign),
    .strobe_out(strobe));

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [REG_AW-1:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic cfg(input logic [FMT_W-1:0] f, input logic b8, input logic w);
    reg_wr(ADDR_CTRL, {28'h0, f, b8});
    width_sw <= w;
  endtask

  // Queue the outcome, then let the controller send the word
  task automatic ex(input logic [15:0] d, input logic s, input logic acc, input int r,
      input logic chk = 1'b1);
    q.push_back({chk, acc, r[23:0]});
    psr_ctrl_model_inst.send(d, s, 1 + ($unsigned($random(seed)) % 3));
    @(negedge clk); // Answer has landed before any direct look at outputs
  endtask

  // Packs a five-digit value onto the lines and the sign
  function automatic logic [16:0] u5(input int v);
    return {2'((v / 10000) % 4), 4'((v / 1000) % 10), 4'((v / 100) % 10),
      4'((v / 10) % 10), 3'((v % 10) / 2)};
  endfunction

  // Results are judged once the edge's updates have landed
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin : watch
    logic [25:0] e;
    if (upd === 1'b1 || rej === 1'b1) begin
      e = q.pop_front();
      cmp("accepted", {31'h0, e[24]}, {31'h0, upd});
      if (e[25] && e[24]) cmp("reference", {8'h0, e[23:0]}, {8'h0, ref_v});
    end
    if (rd_d) cmp("read data", rq.pop_front(), rdata);
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    reg_rd(ADDR_CTRL, 32'h0);
    reg_rd(ADDR_DISP, 32'h0);
    reg_rd(ADDR_CONV_IN, {8'h0, CONV_RESET});
    // Percent BCD: limits, bad digit, sign
    ex(16'h0110, 0, 1, 11000);
    ex(16'h0111, 0, 0, 0);
    ex(16'h00A5, 0, 0, 0);
    ex(16'h0050, 1, 1, -5000);
    reg_rd(ADDR_REF, {8'h0, 24'(-5000)});
    reg_rd(ADDR_MON, {8'h0, 24'(-5000)});
    reg_rd(ADDR_RAW, 32'h00010050);
    reg_rd(ADDR_STATUS, 32'h00000006);
    reg_wr(ADDR_REF, 32'h0);
    reg_rd(ADDR_REF, {8'h0, 24'(-5000)});
    cfg(FMT_PCT01, 0, 1);
    ex(16'h1100, 0, 1, 11000);
    ex(16'h1101, 0, 0, 0);
    cfg(FMT_PCT001, 0, 1);
    ex(16'h9999, 0, 1, 9999);
    cfg(FMT_PCT001, 0, 0);
    ex(16'h5999, 0, 1, 999);
    // Hz BCD limits, then display selector: monitor, rpm and user units
    cfg(FMT_HZ1, 0, 1);
    ex(16'h0400, 0, 1, 0, 0);
    ex(16'h0401, 0, 0, 0);
    cfg(FMT_HZ01, 0, 1);
    ex(16'h4000, 0, 1, 0, 0);
    ex(16'h4001, 0, 0, 0);
    cfg(FMT_HZ001, 0, 1);
    ex(16'h1599, 0, 1, 0, 0);
    cmp("monitor", 32'd1599, {8'h0, mon});
    reg_wr(ADDR_DISP, 32'd1);
    reg_rd(ADDR_DISP, 32'd1);
    cfg(FMT_PCT01, 0, 1);
    ex(16'h0500, 0, 1, 5000);
    cmp("monitor", 32'd5000, {8'h0, mon});
    reg_wr(ADDR_DISP, 32'd4);
    cfg(FMT_PCT1, 0, 1);
    ex(16'hF999, 0, 1, 0, 0);
    cmp("monitor", 32'd15999, {8'h0, mon});
    reg_wr(ADDR_DISP, 32'd11000);
    ex(16'h1000, 0, 1, 1000);
    ex(16'h1001, 0, 0, 0);
    cmp("decimals", 32'd1, {30'h0, mdp});
    reg_wr(ADDR_DISP, 32'd0);
    // Signed binary at both widths
    cfg(FMT_BIN, 0, 1);
    ex(16'hFFFF, 0, 1, 10000);
    ex(16'd33000, 0, 1, 11000);
    ex(16'd33001, 0, 0, 0);
    ex(16'd30000, 1, 1, -10000);
    repeat (6) begin
      m = $unsigned($random(seed)) % 33001;
      ex(16'(m), 0, 1, int'((longint'(m) * 21846 + 32768) >>> 16));
    end
    cfg(FMT_BIN, 0, 0);
    ex(16'hFFFF, 1, 1, -10000);
    ex(16'h0800, 0, 1, int'((longint'(2048) * 160040 + 32768) >>> 16));
    // Eight-line board
    cfg(FMT_BIN, 1, 1);
    ex(16'hFFFF, 0, 1, 10000);
    ex(16'h0080, 1, 1, -int'((longint'(128) * 2570040 + 32768) >>> 16));
    cfg(FMT_U5, 1, 1);
    ex(16'h1234, 0, 0, 0);
    cfg(FMT_HZ1, 1, 1);
    ex(16'hA5F9, 1, 1, -15900);
    ex(16'h00FA, 0, 0, 0);
    // Unsigned five digits: sign line is data
    cfg(FMT_U5, 0, 0);
    w5 = u5(39998);
    ex(w5[15:0], w5[16], 1, 39998);
    cmp("reverse", 32'h0, {31'h0, rev});
    w5 = u5(20000);
    ex(w5[15:0], w5[16], 1, 20000);
    ex(16'h0005, 0, 0, 0);
    repeat (3) @(posedge clk);
    cmp("pending", 32'h0, q.size());
    tally_and_finish();
  end
endmodule
`default_nettype wire
